// ===== hw/bcc_ctrl.sv
// Control-signal sequencer of the external demultiplexed bus.
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Privilege output is low for a supervisor access and high for a user access.
// - Address strobe is low only in the first clock of each bus access.
// - Ready is sampled only after programmed waits, in every data cycle of a region with ready enabled.
// - An enabled burst cut ends the burst and a fresh address cycle follows.
// - Wait status is low while any of the four wait intervals is counted.
// - Final transfer is low in the last data transfer once waits reach zero.
// - Final transfer stays low through ready waits and rises after the last transfer.
// - Transceiver direction is low for reads and high for writes.
// - Transceiver enable falls at the first data cycle and rises after the last.
// - Transceiver enable stays low across all accesses of one request that no backoff interrupts.
// - Transceiver enable stays low across back-to-back pipelined reads.
// - Lock falls in the first clock of an atomic operation and rises with final transfer.
// - Hold is never granted while lock is low.

module bcc_ctrl (
   // Clock and reset
   input  wire logic                        clk,
   input  wire logic                        reset,
   // Register port
   input  wire logic [bcc_pkg::REG_AW-1:0] reg_addr,
   input  wire logic [bcc_pkg::REG_DW-1:0] reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output logic [bcc_pkg::REG_DW-1:0]      reg_rdata,
   // Core request
   input  wire logic                        req_valid,
   input  wire logic                        req_write,
   input  wire logic                        req_super,
   input  wire logic                        req_lock,
   input  wire logic                        req_unlock,
   input  wire logic [bcc_pkg::RGN_W-1:0]  req_region,
   input  wire logic [bcc_pkg::CNT_W-1:0]  req_beats,
   input  wire logic [bcc_pkg::CNT_W-1:0]  req_accesses,
   output logic                             req_taken,
   output logic                             req_done,
   // Bus pins in
   input  wire logic                        ready_in,
   input  wire logic                        burst_cut_in,
   input  wire logic                        hold_req_in,
   input  wire logic                        backoff_in,
   // Bus pins out
   output logic                             addr_strobe_n,
   output logic                             privilege_level_out,
   output logic                             wait_n,
   output logic                             final_xfer_n,
   output logic                             xcvr_direction,
   output logic                             xcvr_enable_n,
   output logic                             lock_n,
   output logic                             hold_grant,
   output logic                             ctrl_oe
);
   import bcc_pkg::*;

   // ****************************************************************
   // Helpers
   // ****************************************************************

   // Selects one of the four wait intervals for the current phase.
   function automatic logic [WAIT_W-1:0] pick_waits(input logic [31:0] w,
                                                    input logic        wr,
                                                    input logic        addr_ph);
      logic [WAIT_W-1:0] v;
      v = '0;
      if (addr_ph) begin
         v = wr ? w[WAD_LSB +: WAIT_W] : w[RAD_LSB +: WAIT_W];
      end else begin
         v = wr ? w[WDD_LSB +: WAIT_W] : w[RDD_LSB +: WAIT_W];
      end
      return v;
   endfunction

   // Reads the enable bit of one region from a per-region field.
   function automatic logic region_bit(input logic [31:0]      r,
                                       input int               lsb,
                                       input logic [RGN_W-1:0] rg);
      return r[lsb + int'(rg)];
   endfunction

   // ****************************************************************
   // Storage
   // ****************************************************************
   bcc_state_t        state_ff,  nxt_state;
   logic [31:0]       waits_ff;
   logic [31:0]       region_ff;
   logic [31:0]       rdata_ff;
   logic              rdy_s1_ff, rdy_s2_ff;
   logic              cut_s1_ff, cut_s2_ff;
   logic              hold_s1_ff, hold_s2_ff;
   logic              boff_s1_ff, boff_s2_ff;
   logic              cur_write_ff, cur_unlock_ff;
   logic [RGN_W-1:0]  cur_region_ff;
   logic [CNT_W-1:0]  beats_len_ff, beat_left_ff, nxt_beat_left;
   logic [CNT_W-1:0]  acc_left_ff, nxt_acc_left;
   logic              taken_ff, done_ff;
   logic              ads_n_ff, priv_ff, wait_n_ff, final_n_ff;
   logic              dir_ff, den_n_ff, lock_n_ff, grant_ff, oe_ff;
   logic              wait_last;
   logic [WAIT_W-1:0] wait_count;

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************

   // Bus inputs come from outside logic, so each passes two flops first.
   always_ff @(posedge clk) begin
      if (reset) begin
         {rdy_s1_ff, rdy_s2_ff, cut_s1_ff, cut_s2_ff}     <= 4'h0;
         {hold_s1_ff, hold_s2_ff, boff_s1_ff, boff_s2_ff} <= 4'h0;
      end else begin
         {rdy_s2_ff, rdy_s1_ff}   <= {rdy_s1_ff, ready_in};
         {cut_s2_ff, cut_s1_ff}   <= {cut_s1_ff, burst_cut_in};
         {hold_s2_ff, hold_s1_ff} <= {hold_s1_ff, hold_req_in};
         {boff_s2_ff, boff_s1_ff} <= {boff_s1_ff, backoff_in};
      end
   end

   // ****************************************************************
   // Access decode
   // ****************************************************************

   // Region controls of the access in flight and of a waiting request.
   wire rdy_en    = region_bit(region_ff, RDY_EN_LSB, cur_region_ff);
   wire cut_en    = region_bit(region_ff, CUT_EN_LSB, cur_region_ff);
   wire pipe_cur  = region_bit(region_ff, PIPE_LSB, cur_region_ff);
   wire pipe_req  = region_bit(region_ff, PIPE_LSB, req_region);
   wire in_xfer   = (state_ff == ST_XFER);
   wire boff      = boff_s2_ff;
   wire lock_act  = !lock_n_ff;

   // Ready counts only in a data cycle, i.e. after all waits; off means no external wait.
   wire xfer_ok   = in_xfer && !boff && (!rdy_en || rdy_s2_ff);
   wire beat_last = (beat_left_ff == '0);
   wire cut       = cut_en && cut_s2_ff && !beat_last;
   wire acc_end   = xfer_ok && (beat_last || cut);
   wire req_end   = acc_end && beat_last && (acc_left_ff == '0);
   wire [WAIT_W-1:0] wait_val = pick_waits(waits_ff, cur_write_ff, state_ff == ST_ADDR);

   // A pipelined read follows a finished read without closing the transceivers.
   // The taken flag guards against seeing the previous request a second time.
   wire pipe_ok   = req_end && !cur_write_ff && pipe_cur && req_valid && !req_write
                    && pipe_req && !req_lock && !lock_act && !taken_ff && !hold_s2_ff;
   wire idle_take = (state_ff == ST_IDLE) && req_valid && !taken_ff
                    && !(hold_s2_ff && !lock_act);
   wire take      = idle_take || pipe_ok;

   // ****************************************************************
   // Sequencer
   // ****************************************************************

   // Next state of the bus access sequence.
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (hold_s2_ff && !lock_act) begin
               nxt_state = ST_HOLD;
            end else if (take) begin
               nxt_state = ST_ADDR;
            end
         end
         ST_ADDR: begin
            if (boff) begin
               nxt_state = ST_BOFF;
            end else begin
               nxt_state = (wait_val != '0) ? ST_WAIT : ST_XFER;
            end
         end
         ST_WAIT: begin
            if (boff) begin
               nxt_state = ST_BOFF;
            end else if (wait_last) begin
               nxt_state = ST_XFER;
            end
         end
         ST_XFER: begin
            if (boff) begin
               nxt_state = ST_BOFF;
            end else if (req_end) begin
               nxt_state = pipe_ok ? ST_ADDR : ST_IDLE;
            end else if (acc_end) begin
               nxt_state = ST_ADDR;
            end else if (xfer_ok) begin
               nxt_state = (wait_val != '0) ? ST_WAIT : ST_XFER;
            end
         end
         ST_HOLD: begin
            if (!hold_s2_ff) begin
               nxt_state = ST_IDLE;
            end
         end
         ST_BOFF: begin
            // The aborted access is regenerated from its address cycle.
            if (!boff) begin
               nxt_state = ST_ADDR;
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   // Beat and access counters; a cut leaves the remaining beats for the new access.
   always_comb begin
      nxt_beat_left = beat_left_ff;
      nxt_acc_left  = acc_left_ff;
      if (take) begin
         nxt_beat_left = req_beats;
         nxt_acc_left  = req_accesses;
      end else if (acc_end && beat_last) begin
         nxt_beat_left = beats_len_ff;
         nxt_acc_left  = acc_left_ff - 2'h1;
      end else if (xfer_ok) begin
         nxt_beat_left = beat_left_ff - 2'h1;
      end
   end

   // Wait-state timer, loaded as the wait phase opens.
   bcc_wait_gen u_wait_gen (
      .clk      (clk),
      .reset    (reset),
      .load     ((nxt_state == ST_WAIT) && (state_ff != ST_WAIT)),
      .load_val (wait_val),
      .run      (state_ff == ST_WAIT),
      .last     (wait_last),
      .count    (wait_count)
   );

   // ****************************************************************
   // Next values of the bus pins
   // ****************************************************************
   wire nxt_active  = (nxt_state == ST_WAIT) || (nxt_state == ST_XFER);
   wire nxt_ads_n   = (nxt_state != ST_ADDR);
   wire nxt_wait_n  = (nxt_state != ST_WAIT);
   wire nxt_final_n = !((nxt_state == ST_XFER) && (nxt_beat_left == '0));
   wire nxt_priv    = take ? !req_super : priv_ff;
   // Enable opens with data, and stays open through later address clocks.
   wire nxt_den_n   = !(nxt_active || ((nxt_state == ST_ADDR) && !den_n_ff));
   // Direction is only retimed while the transceivers are shut.
   wire nxt_dir     = (take && den_n_ff) ? req_write : dir_ff;
   wire nxt_lock_n  = (take && req_lock) ? 1'b0 :
                      ((req_end && cur_unlock_ff) ? 1'b1 : lock_n_ff);
   wire nxt_oe      = (nxt_state != ST_HOLD) && (nxt_state != ST_BOFF);

   // State and request context.
   always_ff @(posedge clk) begin
      if (reset) begin
         state_ff      <= ST_IDLE;
         cur_write_ff  <= 1'b0;
         cur_unlock_ff <= 1'b0;
         cur_region_ff <= '0;
         beats_len_ff  <= '0;
         beat_left_ff  <= '0;
         acc_left_ff   <= '0;
         taken_ff      <= 1'b0;
         done_ff       <= 1'b0;
      end else begin
         state_ff      <= nxt_state;
         beat_left_ff  <= nxt_beat_left;
         acc_left_ff   <= nxt_acc_left;
         taken_ff      <= take;
         done_ff       <= req_end;
         if (take) begin
            cur_write_ff  <= req_write;
            cur_unlock_ff <= req_unlock;
            cur_region_ff <= req_region;
            beats_len_ff  <= req_beats;
         end
      end
   end

   // Pin flops; reset shows every strobe inactive and direction as receive.
   always_ff @(posedge clk) begin
      if (reset) begin
         {ads_n_ff, priv_ff, wait_n_ff, final_n_ff} <= 4'hf;
         {dir_ff, den_n_ff, lock_n_ff}              <= 3'h3;
         {grant_ff, oe_ff}                          <= 2'h1;
      end else begin
         {ads_n_ff, priv_ff, wait_n_ff, final_n_ff} <= {nxt_ads_n, nxt_priv,
                                                        nxt_wait_n, nxt_final_n};
         {dir_ff, den_n_ff, lock_n_ff}              <= {nxt_dir, nxt_den_n, nxt_lock_n};
         {grant_ff, oe_ff}                          <= {nxt_state == ST_HOLD, nxt_oe};
      end
   end

   // ****************************************************************
   // Register port
   // ****************************************************************
   wire [31:0] status_word = {16'h0, wait_count, 2'b00, state_ff, acc_left_ff,
                              beat_left_ff, lock_act, !den_n_ff, grant_ff};
   wire [31:0] rd_mux = (reg_addr == OFF_WAITS)  ? waits_ff  :
                        (reg_addr == OFF_REGION) ? region_ff :
                        (reg_addr == OFF_STATUS) ? status_word : 32'h0;

   // Writes take effect at once; unmapped reads return zero.
   always_ff @(posedge clk) begin
      if (reset) begin
         waits_ff  <= WAITS_RST;
         region_ff <= REGION_RST;
         rdata_ff  <= '0;
      end else begin
         if (reg_wr && (reg_addr == OFF_WAITS)) begin
            waits_ff <= {16'h0, reg_wdata[15:0]};
         end
         if (reg_wr && (reg_addr == OFF_REGION)) begin
            region_ff <= {20'h0, reg_wdata[REGION_USE-1:0]};
         end
         rdata_ff <= reg_rd ? rd_mux : 32'h0;
      end
   end

   assign reg_rdata           = rdata_ff;
   assign req_taken           = taken_ff;
   assign req_done            = done_ff;
   assign addr_strobe_n       = ads_n_ff;
   assign privilege_level_out = priv_ff;
   assign wait_n              = wait_n_ff;
   assign final_xfer_n        = final_n_ff;
   assign xcvr_direction      = dir_ff;
   assign xcvr_enable_n       = den_n_ff;
   assign lock_n              = lock_n_ff;
   assign hold_grant          = grant_ff;
   assign ctrl_oe             = oe_ff;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_addr_clk;
      (state_ff == ST_ADDR) && !boff;
   endsequence

   sequence s_data_open;
      !den_n_ff && ((state_ff == ST_WAIT) || (state_ff == ST_XFER));
   endsequence

   priv_level_a: assert property (take |=> (priv_ff == !$past(req_super)))
      else $error("privilege level changed during address clock");
   ads_one_clk_a: assert property (!ads_n_ff |=> ads_n_ff)
      else $error("address strobe held beyond one clock");
   ready_gate_a: assert property (in_xfer && rdy_en && !rdy_s2_ff && !boff |=> in_xfer)
      else $error("data cycle ended without ready");
   cut_new_addr_a: assert property (xfer_ok && cut && !req_end |=> !ads_n_ff)
      else $error("burst cut not followed by an address clock");
   wait_status_a: assert property (!wait_n_ff == (state_ff == ST_WAIT))
      else $error("wait status does not track the wait timer");
   final_last_a: assert property (!final_n_ff |-> in_xfer && beat_last)
      else $error("final transfer shown outside the last beat");
   final_hold_a: assert property (!final_n_ff && !xfer_ok && !boff |=> !final_n_ff)
      else $error("final transfer dropped during ready waits");
   final_drop_a: assert property (req_end && !pipe_ok |=> final_n_ff
                                 && (lock_n_ff || !cur_unlock_ff))
      else $error("final transfer still low after the last transfer");
   dir_match_a: assert property (!den_n_ff |-> (dir_ff == cur_write_ff))
      else $error("transceiver direction disagrees with access");
   dir_quiet_a: assert property (!den_n_ff && !$past(den_n_ff) |-> $stable(dir_ff))
      else $error("direction changed with transceivers enabled");
   den_open_a: assert property (s_addr_clk and den_n_ff |=> s_data_open)
      else $error("transceiver enable late for first data cycle");
   den_span_a: assert property (acc_end && !req_end |=> !den_n_ff ##1 (!den_n_ff || boff_s2_ff))
      else $error("transceiver enable dropped between accesses");
   den_pipe_a: assert property (pipe_ok |=> !den_n_ff && !ads_n_ff)
      else $error("transceiver enable dropped between pipelined reads");
   lock_first_a: assert property (take && req_lock |=> !lock_n_ff && !ads_n_ff)
      else $error("lock not low in first clock of atomic operation");
   hold_lock_a: assert property (!lock_n_ff |-> !grant_ff)
      else $error("hold granted while locked");
   float_a: assert property (grant_ff |-> !oe_ff && ads_n_ff)
      else $error("outputs driven during hold");

endmodule
`default_nettype wire

// ===== common/bcc_pkg.sv
// Package of constants and types shared by the bus cycle control block.
package bcc_pkg;

   // ****************************************************************
   // Register port geometry and offsets
   // ****************************************************************
   localparam int          REG_AW     = 8;
   localparam int          REG_DW     = 32;
   localparam logic [7:0]  OFF_WAITS  = 8'h00;
   localparam logic [7:0]  OFF_REGION = 8'h04;
   localparam logic [7:0]  OFF_STATUS = 8'h08;

   // ****************************************************************
   // Field layout of the wait-state register
   // ****************************************************************
   localparam int          WAIT_W     = 4;
   localparam int          WAD_LSB    = 0;
   localparam int          RAD_LSB    = 4;
   localparam int          WDD_LSB    = 8;
   localparam int          RDD_LSB    = 12;
   localparam logic [31:0] WAITS_RST  = 32'h0000_0000;

   // ****************************************************************
   // Field layout of the region control register
   // ****************************************************************
   localparam int          REGION_N   = 4;
   localparam int          RGN_W      = 2;
   localparam int          RDY_EN_LSB = 0;
   localparam int          CUT_EN_LSB = 4;
   localparam int          PIPE_LSB   = 8;
   localparam int          REGION_USE = 12;
   localparam logic [31:0] REGION_RST = 32'h0000_0000;

   // ****************************************************************
   // Request geometry and sequencer states
   // ****************************************************************
   localparam int          CNT_W      = 2;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_WAIT,
      ST_XFER,
      ST_HOLD,
      ST_BOFF
   } bcc_state_t;

endpackage

// ===== hw/bcc_wait_gen.sv
// Down counter that times the programmed wait states of a bus access.
`timescale 1ns/100ps
`default_nettype none

module bcc_wait_gen (
   // Clock and reset
   input  wire logic                        clk,
   input  wire logic                        reset,
   // Control
   input  wire logic                        load,
   input  wire logic [bcc_pkg::WAIT_W-1:0] load_val,
   input  wire logic                        run,
   // Status
   output logic                             last,
   output logic [bcc_pkg::WAIT_W-1:0]      count
);
   import bcc_pkg::*;

   logic [WAIT_W-1:0] count_ff;

   // The counter is loaded on entry to the wait phase and steps down once per wait clock.
   always_ff @(posedge clk) begin
      if (reset) begin
         count_ff <= '0;
      end else if (load) begin
         count_ff <= load_val;
      end else if (run && (count_ff != '0)) begin
         count_ff <= count_ff - 4'h1;
      end
   end

   // The final wait clock is the one where a single count remains.
   assign last  = (count_ff == 4'h1);
   assign count = count_ff;

endmodule
`default_nettype wire

// ===== dv/bcc_mem_model.sv
// Behavioural memory subsystem that answers the bus cycle control block.
`timescale 1ns/100ps
`default_nettype none

module bcc_mem_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset,
   // Bus side seen by the memory
   input  wire logic       xcvr_enable_n,
   input  wire logic [1:0] stall,
   input  wire logic       cut_cmd,
   // Answers
   output logic            ready_in,
   output logic            burst_cut_in
);
   logic [1:0] cnt_ff;

   // Ready rises after a chosen stall in a data phase and drops when the phase ends.
   // Ready is an active-high level with low as its idle state, so the model drives it low.
   always_ff @(posedge clk) begin
      cnt_ff       <= (reset || xcvr_enable_n) ? 2'h0 : cnt_ff + {1'b0, cnt_ff != stall};
      ready_in     <= !reset && !xcvr_enable_n && cnt_ff == stall;
      burst_cut_in <= !reset && !xcvr_enable_n && cnt_ff == stall && cut_cmd;
   end
endmodule

`default_nettype wire

// ===== dv/test_bus_cycle_control_signals.sv
// Self-checking testbench of the bus cycle control sequencer.
`timescale 1ns/100ps
`default_nettype none

module test_bus_cycle_control_signals;
   import bcc_pkg::*;
   logic        clk, reset, reg_wr, reg_rd, req_valid, req_write, req_super, req_lock;
   logic        req_unlock, req_taken, req_done, ready_in, burst_cut_in, hold_req_in;
   logic        backoff_in, addr_strobe_n, privilege_level_out, wait_n, final_xfer_n;
   logic        xcvr_direction, xcvr_enable_n, lock_n, hold_grant, ctrl_oe, cut_cmd;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, seed;
   logic [1:0]  req_region, req_beats, req_accesses, stall;
   logic [15:0] waits;
   logic [11:0] region;
   int          num_errors, num_checks, cyc, i;

   bcc_ctrl u_dut (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .req_valid, .req_write, .req_super, .req_lock, .req_unlock, .req_region, .req_beats,
      .req_accesses, .req_taken, .req_done, .ready_in, .burst_cut_in, .hold_req_in,
      .backoff_in, .addr_strobe_n, .privilege_level_out, .wait_n, .final_xfer_n,
      .xcvr_direction, .xcvr_enable_n, .lock_n, .hold_grant, .ctrl_oe);
   bcc_mem_model u_mem (.clk, .reset, .xcvr_enable_n, .stall, .cut_cmd, .ready_in,
      .burst_cut_in);

   // ****************************************************************
   // Clock, timeout and reporting
   // ****************************************************************
   // Clock of 8 ns; the cycle ceiling stops a hung request loop.
   always #4 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         num_errors++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("checks=%0d errors=%0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // ****************************************************************
   // Register port and request drivers
   // ****************************************************************
   // Each strobe stands one cycle; read data is sampled just after the answer edge.
   // An idle clock closes each access so no strobe is assigned twice in one step.
   task automatic reg_acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= wr;
      reg_rd <= !wr;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1;
      if (!wr)
         check(reg_rdata, d);
      @(posedge clk);
   endtask

   // Programmed waits per access: address-to-data once, data-to-data between beats.
   function automatic int exp_waits(input logic w, input logic [1:0] bt, input logic [1:0] ac);
      return (int'(w ? waits[3:0] : waits[7:4]) + int'(w ? waits[11:8] : waits[15:12])
              * int'(bt)) * (int'(ac) + 1);
   endfunction

   // Issues one request, watches it to completion and compares what the pins showed.
   task automatic run_req(input logic w, s, lk, input logic [1:0] rg, bt, ac);
      int   n_as, n_wt, n_fin, k;
      logic en_seen, gap, rdy, cut;
      {n_as, n_wt, n_fin, en_seen, gap} = '0;
      rdy = region[RDY_EN_LSB + rg];
      cut = region[CUT_EN_LSB + rg] && cut_cmd && bt != 2'h0;
      {req_write, req_super, req_lock, req_unlock} <= {w, s, lk, lk};
      {req_region, req_beats, req_accesses, req_valid} <= {rg, bt, ac, 1'b1};
      hold_req_in <= lk;
      for (k = 0; k < 900 && req_done !== 1'b1; k++) begin
         @(posedge clk);
         #1;
         if (req_taken === 1'b1)
            req_valid <= 1'b0;
         if (addr_strobe_n === 1'b0) begin
            n_as++;
            check(privilege_level_out, !s);
            check(lock_n, !lk);
         end
         if (xcvr_enable_n === 1'b0)
            check(xcvr_direction, w);
         if (lk)
            check(hold_grant, 1'b0);
         n_wt += int'(wait_n === 1'b0);
         n_fin += int'(final_xfer_n === 1'b0);
         gap |= en_seen && xcvr_enable_n !== 1'b0 && req_done !== 1'b1;
         en_seen |= xcvr_enable_n === 1'b0;
      end
      hold_req_in <= 1'b0;
      check(req_done, 1'b1);
      check(gap, 1'b0);
      check(cut ? n_as > ac : n_as == ac + 1, 1'b1);
      check(rdy || cut ? n_fin > ac : n_fin == ac + 1, 1'b1);
      if (!cut)
         check(n_wt, exp_waits(w, bt, ac));
      @(posedge clk);
      #1;
      check({lock_n, xcvr_enable_n, final_xfer_n}, 3'h7);
   endtask

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      {clk, reg_wr, reg_rd, req_valid, req_write, req_super, req_lock, req_unlock} = '0;
      {hold_req_in, backoff_in, cut_cmd, reg_addr, reg_wdata, stall, cyc} = '0;
      {req_region, req_beats, req_accesses, waits, region, num_errors, num_checks} = '0;
      seed = 32'hb07e;
      reset = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      check({addr_strobe_n, privilege_level_out, wait_n, final_xfer_n, xcvr_enable_n,
             lock_n, xcvr_direction, hold_grant}, 8'hfc);
      reset <= 1'b0;
      @(posedge clk);
      reg_acc(1'b0, 8'h0c, 32'h0);
      run_req(1'b0, 1'b1, 1'b0, 2'h0, 2'h0, 2'h0);
      run_req(1'b1, 1'b0, 1'b1, 2'h1, 2'h3, 2'h1);
      // Random waits, regions, stalls and cuts; waits and regions are read back first.
      for (i = 0; i < 30; i++) begin
         waits = 16'($random(seed));
         region = 12'($random(seed));
         {stall, cut_cmd} = 3'($random(seed));
         reg_acc(1'b1, OFF_WAITS, {16'h0, waits});
         reg_acc(1'b1, OFF_REGION, {20'h0, region});
         reg_acc(1'b0, OFF_WAITS, {16'h0, waits});
         reg_acc(1'b0, OFF_REGION, {20'h0, region});
         run_req(1'($random(seed)), 1'($random(seed)), 1'($random(seed)),
                 2'($random(seed)), 2'($random(seed)), 2'($random(seed)));
      end
      // An idle hold is granted and the control outputs float.
      hold_req_in <= 1'b1;
      for (i = 0; i < 10 && hold_grant !== 1'b1; i++)
         @(posedge clk);
      #1;
      check({hold_grant, ctrl_oe}, 2'h2);
      stop_test();
   end
endmodule

`default_nettype wire
